// ### hw/usbmcs_pkg.sv
// package: register map and field layout of the usb mode/clock status bank
// assumes: used by usbmcs_regs over an ahb-lite slave port
`default_nettype none
package usbmcs_pkg;
	// printed offsets 0x21/0x22 are not word multiples: kept as indexes
	localparam logic [7:0] usbmcs_idx_status = 8'h21;
	localparam logic [7:0] usbmcs_idx_clock = 8'h22;
	localparam logic [7:0] usbmcs_idx_irq_status = 8'h30;
	localparam logic [7:0] usbmcs_idx_irq_mask = 8'h31;
	localparam int usbmcs_ep_count = 4;
	localparam int usbmcs_pos_pad_mode = 4;
	localparam int usbmcs_pos_usb_flag = 7;
	localparam int usbmcs_pos_pullup_sel = 2;
	localparam int usbmcs_pos_clk_gate = 3;
	localparam int usbmcs_pos_bandgap_off = 4;
	localparam int usbmcs_pos_legacy_flag = 5;
	localparam int usbmcs_pos_osc_sel = 6;
	localparam int usbmcs_pos_trim_dis = 7;
	localparam logic [7:0] usbmcs_status_reset = 8'h00;
	localparam logic [7:0] usbmcs_clock_reset = 8'h00;
	localparam logic [7:0] usbmcs_clock_wmask = 8'hFC;
	localparam logic [7:0] usbmcs_status_wmask = 8'hBF;
	typedef enum logic [1:0] {
		usbmcs_pad_off = 2'h0,
		usbmcs_pad_200r = 2'h1,
		usbmcs_pad_usb = 2'h2,
		usbmcs_pad_on = 2'h3
	} usbmcs_pad_t;
endpackage
`default_nettype wire

// ### hw/usbmcs_regs.sv
// file: usb endpoint status/mode and clock control registers, ahb-lite slave
// assumes: single-word transfers, one clock hclk, engine inputs synchronous
// Behaviour
// RULE_01 - a host access sets its flag; usb irq if enabled, stack not full.
// RULE_02 - firmware clears a serviced flag by writing 0; else it stays set.
// RULE_03 - endpoint flags 0 to 3 sit in status bits 3:0, read/write.
// RULE_04 - pad mode bits 5:4 reset to 00: non-usb, 3.3 V off, pins r/w.
// RULE_05 - pad mode 10 is usb: 1.5k pull-up, 3.3 V on, pins read-only.
// RULE_06 - pad mode 01 adds a 200 ohm supply path, 11 turns 3.3 V on.
// RULE_07 - status bit 7 is a firmware usb-mode flag, cleared at reset.
// RULE_08 - clock bit 5 is a firmware legacy port mode flag, reset 0.
// RULE_09 - clock bits 1:0 are reserved and read 0.
// RULE_10 - clock bit 2 connects the 7.5k supply pull-up, drops the 1.5k.
// RULE_11 - clock bit 3 enables the usb clock, reset 0.
// RULE_12 - clock bit 4 switches off the band-gap, reset 0.
// RULE_13 - clock bit 6 declares a 6 MHz oscillator when 1, 12 MHz when 0.
// RULE_14 - clock bit 7 disables clock temperature trim when 1, reset 0.
// RULE_15 - firmware should set the trim disable bit before power-down.
// RULE_16 - in usb pad mode the engine drives both pins; fw writes ignored.
// RULE_17 - an engine set in the same cycle as a firmware clear wins.
//
// Decided for this implementation: the AHB-Lite register port.
`default_nettype none
module usbmcs_regs (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [3:0] endpoint_access,
	input wire logic usb_int_enable,
	input wire logic stack_full,
	output logic usb_interrupt,
	output logic irq,
	input wire logic engine_minus_out,
	input wire logic engine_plus_out,
	input wire logic engine_drive_en,
	input wire logic fw_minus_out,
	input wire logic fw_plus_out,
	input wire logic fw_drive_en,
	input wire logic minus_data_pin_in,
	input wire logic plus_data_pin_in,
	output logic minus_data_pin_out,
	output logic plus_data_pin_out,
	output logic minus_data_pin_oe,
	output logic plus_data_pin_oe,
	output logic fw_minus_in,
	output logic fw_plus_in,
	output logic regulated_output_enable,
	output logic regulated_output_200r,
	output logic pullup_1k5_connect,
	output logic pullup_7k5_connect,
	output logic bus_clock_gate,
	output logic bandgap_shutdown,
	output logic oscillator_frequency_select,
	output logic clock_trim_disable,
	output logic usb_mode_indicator,
	output logic legacy_port_mode_indicator
);
	logic [7:0] status_reg, next_status_reg;
	logic [7:0] clock_reg, next_clock_reg;
	logic [3:0] irq_status, next_irq_status;
	logic [3:0] irq_mask, next_irq_mask;
	logic wr_pend, next_wr_pend;
	logic [7:0] wr_idx, next_wr_idx;
	logic [31:0] next_hrdata;
	logic [7:0] a_idx;
	logic take;
	usbmcs_pkg::usbmcs_pad_t pad;

	// unaligned printed offsets: byte address is four times the index
	assign a_idx = haddr[9:2];
	assign take = hsel && hready && htrans[1];
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign pad = usbmcs_pkg::usbmcs_pad_t'(
		status_reg[usbmcs_pkg::usbmcs_pos_pad_mode +: 2]);

	always_comb begin
		next_status_reg = status_reg;
		next_clock_reg = clock_reg;
		next_irq_status = irq_status;
		next_irq_mask = irq_mask;
		next_wr_pend = take && hwrite;
		next_wr_idx = take ? a_idx : wr_idx;
		next_hrdata = hrdata;
		if (wr_pend) begin
			case (wr_idx)
				usbmcs_pkg::usbmcs_idx_status: begin
					// [RULE_03] [RULE_04] [RULE_07] bit 6 reserved, kept 0
					next_status_reg = hwdata[7:0] & usbmcs_pkg::usbmcs_status_wmask;
				end
				usbmcs_pkg::usbmcs_idx_clock: begin
					// [RULE_09] [RULE_08] [RULE_10] [RULE_11] [RULE_12] [RULE_13] [RULE_14]
					next_clock_reg = hwdata[7:0] & usbmcs_pkg::usbmcs_clock_wmask;
				end
				usbmcs_pkg::usbmcs_idx_irq_mask: begin
					next_irq_mask = hwdata[3:0];
				end
				default: begin
					next_irq_mask = irq_mask;
				end
			endcase
		end
		if (take && !hwrite) begin
			case (a_idx)
				// a write still in its data phase is forwarded to a pipelined read
				usbmcs_pkg::usbmcs_idx_status: begin
					next_hrdata = {24'h000000, next_status_reg};
				end
				usbmcs_pkg::usbmcs_idx_clock: begin
					next_hrdata = {24'h000000, next_clock_reg};
				end
				usbmcs_pkg::usbmcs_idx_irq_status: begin
					next_hrdata = {28'h0000000, irq_status};
					// read clears; a same-cycle event is re-set below
					next_irq_status = 4'h0;
				end
				usbmcs_pkg::usbmcs_idx_irq_mask: begin
					next_hrdata = {28'h0000000, next_irq_mask};
				end
				default: next_hrdata = 32'h00000000;
			endcase
		end
		// engine sets last so they win over any clear [RULE_01] [RULE_17]
		next_status_reg[3:0] = next_status_reg[3:0] | endpoint_access;
		next_irq_status = next_irq_status | endpoint_access;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status_reg <= usbmcs_pkg::usbmcs_status_reset;
			clock_reg <= usbmcs_pkg::usbmcs_clock_reset;
			irq_status <= 4'h0;
			irq_mask <= 4'h0;
			wr_pend <= 1'b0;
			wr_idx <= 8'h00;
			hrdata <= 32'h00000000;
		end else begin
			status_reg <= next_status_reg;
			clock_reg <= next_clock_reg;
			irq_status <= next_irq_status;
			irq_mask <= next_irq_mask;
			wr_pend <= next_wr_pend;
			wr_idx <= next_wr_idx;
			hrdata <= next_hrdata;
		end
	end

	// flags stay set until firmware clears them [RULE_02]
	assign usb_interrupt = (|status_reg[3:0]) && usb_int_enable
		&& !stack_full; // [RULE_01]
	assign irq = |(irq_status & irq_mask);

	// pad control
	always_comb begin
		regulated_output_enable = 1'b0;
		regulated_output_200r = 1'b0;
		pullup_1k5_connect = 1'b0;
		case (pad)
			usbmcs_pkg::usbmcs_pad_off: regulated_output_enable = 1'b0; // [RULE_04]
			usbmcs_pkg::usbmcs_pad_200r: regulated_output_200r = 1'b1; // [RULE_06]
			usbmcs_pkg::usbmcs_pad_usb: begin
				regulated_output_enable = 1'b1; // [RULE_05]
				pullup_1k5_connect = !pullup_7k5_connect; // [RULE_10]
			end
			usbmcs_pkg::usbmcs_pad_on: regulated_output_enable = 1'b1; // [RULE_06]
			default: regulated_output_enable = 1'b0;
		endcase
		// engine owns pins in usb mode; firmware drive ignored [RULE_16] [RULE_05]
		if (pad == usbmcs_pkg::usbmcs_pad_usb) begin
			minus_data_pin_out = engine_minus_out;
			plus_data_pin_out = engine_plus_out;
			minus_data_pin_oe = engine_drive_en;
			plus_data_pin_oe = engine_drive_en;
		end else begin
			minus_data_pin_out = fw_minus_out; // [RULE_04] [RULE_06]
			plus_data_pin_out = fw_plus_out;
			minus_data_pin_oe = fw_drive_en;
			plus_data_pin_oe = fw_drive_en;
		end
	end

	assign fw_minus_in = minus_data_pin_in;
	assign fw_plus_in = plus_data_pin_in;
	assign pullup_7k5_connect =
		clock_reg[usbmcs_pkg::usbmcs_pos_pullup_sel]; // [RULE_10]
	assign bus_clock_gate =
		clock_reg[usbmcs_pkg::usbmcs_pos_clk_gate]; // [RULE_11]
	assign bandgap_shutdown =
		clock_reg[usbmcs_pkg::usbmcs_pos_bandgap_off]; // [RULE_12]
	assign oscillator_frequency_select =
		clock_reg[usbmcs_pkg::usbmcs_pos_osc_sel]; // [RULE_13]
	// trim disable before power-down is up to firmware, not forced here
	assign clock_trim_disable =
		clock_reg[usbmcs_pkg::usbmcs_pos_trim_dis]; // [RULE_14]
	assign usb_mode_indicator =
		status_reg[usbmcs_pkg::usbmcs_pos_usb_flag]; // [RULE_07]
	assign legacy_port_mode_indicator =
		clock_reg[usbmcs_pkg::usbmcs_pos_legacy_flag]; // [RULE_08]

	property p_flag_set;
		@(posedge hclk) disable iff (!hresetn)
		(|endpoint_access) |=>
			((status_reg[3:0] & $past(endpoint_access)) == $past(endpoint_access));
	endproperty
	a_flag_set: assert property (p_flag_set) // [RULE_01]
		else $error("flag not set");

	property p_set_wins;
		@(posedge hclk) disable iff (!hresetn)
		(wr_pend && wr_idx == usbmcs_pkg::usbmcs_idx_status && (|endpoint_access))
			|=> ((status_reg[3:0] & $past(endpoint_access))
			== $past(endpoint_access));
	endproperty
	a_set_wins: assert property (p_set_wins) // [RULE_17]
		else $error("set lost to clear");

	property p_flag_hold;
		@(posedge hclk) disable iff (!hresetn)
		!(wr_pend && wr_idx == usbmcs_pkg::usbmcs_idx_status) |=>
			((status_reg[3:0] & $past(status_reg[3:0]))
			== $past(status_reg[3:0]));
	endproperty
	a_flag_hold: assert property (p_flag_hold) // [RULE_02]
		else $error("flag dropped");

	property p_int;
		@(posedge hclk) disable iff (!hresetn)
		usb_interrupt |-> (|status_reg[3:0]) && usb_int_enable
			&& !stack_full;
	endproperty
	a_int: assert property (p_int) // [RULE_01]
		else $error("bad usb interrupt");

	property p_reserved;
		@(posedge hclk) disable iff (!hresetn)
		clock_reg[1:0] == 2'h0 && status_reg[6] == 1'b0;
	endproperty
	a_reserved: assert property (p_reserved) // [RULE_09]
		else $error("reserved bits set");

	property p_usb_pins;
		@(posedge hclk) disable iff (!hresetn)
		status_reg[5:4] == 2'h2 |->
			minus_data_pin_oe == engine_drive_en && regulated_output_enable
			&& plus_data_pin_out == engine_plus_out;
	endproperty
	a_usb_pins: assert property (p_usb_pins) // [RULE_16]
		else $error("pins not engine owned");

	property p_pad_off;
		@(posedge hclk) disable iff (!hresetn)
		status_reg[5:4] == 2'h0 |-> !regulated_output_enable && !pullup_1k5_connect;
	endproperty
	a_pad_off: assert property (p_pad_off) // [RULE_04]
		else $error("output on in mode 00");

	property p_pad_200r;
		@(posedge hclk) disable iff (!hresetn)
		regulated_output_200r |-> status_reg[5:4] == 2'h1;
	endproperty
	a_pad_200r: assert property (p_pad_200r) // [RULE_06]
		else $error("200r wrong mode");

	property p_pullup;
		@(posedge hclk) disable iff (!hresetn)
		!(pullup_7k5_connect && pullup_1k5_connect);
	endproperty
	a_pullup: assert property (p_pullup) // [RULE_10]
		else $error("both pull-ups on");

	property p_clk_write;
		@(posedge hclk) disable iff (!hresetn)
		(wr_pend && wr_idx == usbmcs_pkg::usbmcs_idx_clock) |=>
			bus_clock_gate == $past(hwdata[3]);
	endproperty
	a_clk_write: assert property (p_clk_write) // [RULE_11]
		else $error("clock gate not written");

	property p_fw_pins;
		@(posedge hclk) disable iff (!hresetn)
		status_reg[5:4] != 2'h2 |->
			minus_data_pin_oe == fw_drive_en && plus_data_pin_out == fw_plus_out;
	endproperty
	a_fw_pins: assert property (p_fw_pins) // [RULE_06]
		else $error("firmware lost the pins");

	property p_rd_status;
		@(posedge hclk) disable iff (!hresetn)
		(take && !hwrite && a_idx == usbmcs_pkg::usbmcs_idx_status && !wr_pend)
			|=> hrdata == {24'h000000, $past(status_reg)};
	endproperty
	a_rd_status: assert property (p_rd_status) // [RULE_03]
		else $error("status read data wrong");

	property p_irq_set;
		@(posedge hclk) disable iff (!hresetn)
		(|endpoint_access) |=>
			((irq_status & $past(endpoint_access)) == $past(endpoint_access));
	endproperty
	a_irq_set: assert property (p_irq_set) // [RULE_01]
		else $error("event status not set");

	property p_irq_clear;
		@(posedge hclk) disable iff (!hresetn)
		(take && !hwrite && a_idx == usbmcs_pkg::usbmcs_idx_irq_status)
			|=> irq_status == $past(endpoint_access);
	endproperty
	a_irq_clear: assert property (p_irq_clear) // [RULE_17]
		else $error("event status read-clear wrong");

	c_event: cover property (@(posedge hclk) endpoint_access[0] ##1 usb_interrupt);
	c_usb: cover property (@(posedge hclk) status_reg[5:4] == 2'h2);
	c_irq: cover property (@(posedge hclk) irq);
	c_collide: cover property (@(posedge hclk) wr_pend
		&& wr_idx == usbmcs_pkg::usbmcs_idx_status && (|endpoint_access));
	c_stack_full: cover property (@(posedge hclk) (|endpoint_access)
		&& stack_full);
endmodule
`default_nettype wire

// ### sim/tb_top.sv
// file: self-checking bench for the usb mode/clock register bank
// assumes: usbmcs_regs and usbmcs_host_model compiled before it
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic hclk, hresetn, hsel, hwrite, hready, hro, hresp, ue, sf, ui, irq;
	logic [31:0] haddr, hwdata, hrdata, r, rnd, v, sv;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [3:0] req, ea, acc;
	logic emo, epo, eoe, fmo, fpo, foe, mi, pi, mo, po, moe, poe, fmi, fpi;
	logic ren, r200, p15, p75, cg, bg, osc, trim, uind, lind, sel;
	logic pat = 1'b0;
	logic [9:0] pv;
	int n_mismatch = 0;
	int checks = 0;
	usbmcs_host_model usbmcs_host_model_inst (.hclk(hclk), .hresetn(hresetn),
		.access_req(req), .endpoint_access(ea), .engine_minus_out(emo),
		.engine_plus_out(epo), .engine_drive_en(eoe));
	usbmcs_regs usbmcs_regs_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hro),
		.hresp(hresp), .endpoint_access(ea), .usb_int_enable(ue),
		.stack_full(sf), .usb_interrupt(ui), .irq(irq),
		.engine_minus_out(emo), .engine_plus_out(epo), .engine_drive_en(eoe),
		.fw_minus_out(fmo), .fw_plus_out(fpo), .fw_drive_en(foe),
		.minus_data_pin_in(mi), .plus_data_pin_in(pi),
		.minus_data_pin_out(mo), .plus_data_pin_out(po),
		.minus_data_pin_oe(moe), .plus_data_pin_oe(poe),
		.fw_minus_in(fmi), .fw_plus_in(fpi), .regulated_output_enable(ren),
		.regulated_output_200r(r200), .pullup_1k5_connect(p15),
		.pullup_7k5_connect(p75), .bus_clock_gate(cg), .bandgap_shutdown(bg),
		.oscillator_frequency_select(osc), .clock_trim_disable(trim),
		.usb_mode_indicator(uind), .legacy_port_mode_indicator(lind));
	assign hready = hro;
	assign pv = {ren, r200, p15, moe, mo, poe, po, fmi, fpi, uind};
	// minus line has a pull-up; plus floats, so it shows a moving pattern
	assign mi = moe ? mo : 1'b1;
	assign pi = poe ? po : pat;
	always @(posedge hclk) pat <= ~pat;
	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e)
			$display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
		n_mismatch += int'(s !== e);
	endtask
	task automatic edge_rdy;
		for (int i = 0; i < 40; i++) begin
			@(posedge hclk);
			if (hro === 1'b1)
				return;
		end
		n_mismatch++;
		stop_test();
	endtask
	task automatic xfer(input logic w, input logic [31:0] a, d);
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		edge_rdy();
		htrans <= 2'h0;
		hwdata <= d;
		edge_rdy();
		r = hrdata;
	endtask
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [9:0] exp_pad(input logic [1:0] md);
		logic u;
		u = md == 2'h2;
		return {md[1], md == 2'h1, u & ~sel, u ? eoe : foe, u ? emo : fmo,
			u ? eoe : foe, u ? epo : fpo, mi, pi, sv[7]};
	endfunction
	initial begin
		{hresetn, hwrite, htrans, haddr, hwdata, ue, sf, req} = '0;
		{fmo, fpo, foe} = '0;
		hsel = 1'b1;
		hsize = 3'h2;
		rnd = 32'hF20D;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		xfer(1'b1, 32'h8C, '1);
		for (int k = 0; k < 4; k++) begin
			xfer(1'b0, k == 3 ? 32'hC0 : 32'h84 + 32'(4 * k), '0);
			chk(r, '0);
		end
		chk({hresp, uind, lind, p75, cg, bg, osc, trim}, '0);
		$display("test reset done");
		for (int k = 0; k < 6; k++) begin
			rnd = lfsr(rnd);
			v = k == 0 ? '1 : rnd;
			xfer(1'b1, 32'h88, v);
			xfer(1'b0, 32'h88, '0);
			chk(r, {v[7:2], 2'h0});
			chk({trim, osc, lind, bg, cg, p75}, v[7:2]);
		end
		$display("test clock done");
		// second pass repeats every mode with the supply pull-up chosen
		for (int md = 0; md < 8; md++) begin
			rnd = lfsr(rnd);
			sel = md[2];
			{fmo, fpo, foe} <= rnd[2:0];
			sv = {24'h0, rnd[7], 1'b0, 2'(md), 4'h0};
			xfer(1'b1, 32'h88, {29'h0, sel, 2'h0});
			xfer(1'b1, 32'h84, sv | 32'h40);
			xfer(1'b0, 32'h84, '0);
			chk(r, sv);
			@(negedge hclk);
			chk(pv, exp_pad(2'(md)));
			chk(p75, sel);
			@(posedge hclk);
		end
		$display("test pad done");
		ue <= 1'b1;
		xfer(1'b1, 32'hC4, 32'hF);
		xfer(1'b0, 32'hC4, '0);
		chk(r, 32'hF);
		acc = 4'h0;
		for (int ep = 0; ep < 4; ep++) begin
			req <= 4'(1 << ep);
			sf <= ep[0];
			@(posedge hclk);
			req <= 4'h0;
			repeat (2) @(posedge hclk);
			acc[ep] = 1'b1;
			chk({ui, irq}, {~ep[0], 1'b1});
			xfer(1'b0, 32'hC0, '0);
			chk(r, 32'(1 << ep));
			xfer(1'b0, 32'h84, '0);
			chk(r, sv | acc);
		end
		// clearing write collides with a new event on endpoint two
		xfer(1'b1, 32'hC4, '0);
		ue <= 1'b0;
		sf <= 1'b0;
		req <= 4'h4;
		fork
			xfer(1'b1, 32'h84, sv);
			begin
				@(posedge hclk);
				req <= 4'h0;
			end
		join
		xfer(1'b0, 32'h84, '0);
		chk(r, sv | 32'h4);
		chk({ui, irq}, '0);
		$display("test events done");
		// trim off ahead of power-down, then a power-on reset mid-run
		xfer(1'b1, 32'h88, 32'h80);
		@(negedge hclk);
		chk(trim, 1'b1);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk({trim, uind, lind, p75, ren, p15, irq}, '0);
		xfer(1'b0, 32'h84, '0);
		chk(r, '0);
		xfer(1'b0, 32'h88, '0);
		chk(r, '0);
		$display("test reset again done");
		stop_test();
	end
endmodule
`default_nettype wire

// ### sim/usbmcs_host_model.sv
// file: behavioural host/engine model: endpoint access events and bus pins
// assumes: one clock hclk, async active-low hresetn, requests from the bench
`default_nettype none
module usbmcs_host_model (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [3:0] access_req,
	output logic [3:0] endpoint_access,
	output logic engine_minus_out,
	output logic engine_plus_out,
	output logic engine_drive_en
);
	timeunit 1ns;
	timeprecision 1ns;
	// a token is decoded one cycle after the bench asks for it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			endpoint_access <= 4'h0;
			engine_minus_out <= 1'b0;
			engine_plus_out <= 1'b1;
			engine_drive_en <= 1'b0;
		end else begin
			endpoint_access <= access_req;
			// pins toggle every cycle so a stuck pad mux cannot hide
			engine_minus_out <= ~engine_minus_out;
			engine_plus_out <= engine_minus_out;
			engine_drive_en <= 1'b1;
		end
	end
endmodule
`default_nettype wire
